// >>> core/fscm_pkg.sv
package fscm_pkg;

	// ************************************************************
	// register map (byte addresses, one aligned word each)
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DEFAULT = 8'h04;
	localparam logic [7:0] ADDR_DEACT = 8'h08;
	localparam logic [7:0] ADDR_TBL_IDX = 8'h0C;
	localparam logic [7:0] ADDR_TBL_DATA = 8'h10;
	localparam logic [7:0] ADDR_STANDBY = 8'h14;
	localparam logic [7:0] ADDR_TIMING = 8'h18;
	localparam logic [7:0] ADDR_SIGMAP = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h28;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h2C;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_FIXED = 0;
	localparam int CTRL_SWMON = 1;
	localparam int CTRL_FBMON = 2;
	localparam int CTRL_FCLR = 3;
	localparam int TIM_CHG_LSB = 0;
	localparam int TIM_RESP_LSB = 16;
	localparam int SIGMAP_STRIDE = 4;
	localparam int STAT_TRIPLE_LSB = 8;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_SWFAULT = 1;
	localparam int IRQ_FBFAULT = 2;
	localparam int IRQ_CHANGED = 3;

	// ************************************************************
	// sizes, reset values, timing
	// ************************************************************
	localparam int TRIPLE_W = 5;
	localparam int NUM_TRIPLES = 32;
	localparam int NUM_IND = 4;
	localparam int NUM_GROUPS = 6;
	localparam int IRQ_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] RST_TBL_ROW = 32'hFFFFFFFF;
	localparam logic [15:0] RST_SIGMAP = 16'h3210;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FB_WINDOW_MS = 500;
	localparam int SYNC_MS = 25;

	// ************************************************************
	// types
	// ************************************************************
	typedef struct packed {
		logic fixedMode;
		logic switchMonEn;
		logic feedbackMonEn;
	} fscm_cfg_t;

	typedef enum logic [2:0] {
		ST_OFF, ST_ON_CHECK, ST_ON, ST_OFF_CHECK, ST_FAULT
	} fscm_state_t;

endpackage : fscm_pkg

// >>> core/fscm_top.sv
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module fscm_top import fscm_pkg::*; #(
	parameter int MS_CYCLES = CYCLES_PER_MS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins from controller, contactors and measurement
	input wire logic [TRIPLE_W-1:0] fieldSelect,
	input wire logic contactorFeedback,
	input wire logic protFieldViolated,
	input wire logic warnFieldViolated,
	// outputs
	output logic [1:0] safetySwitchingOutput,
	output logic [NUM_IND-1:0] indication,
	output logic irq
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [TRIPLE_W+2:0] pinMeta, pinSync;
	logic [TRIPLE_W-1:0] selSync;
	logic fbClosed, protViol, warnViol;

	// two stages, first stage read only by the second
	always_ff @(posedge clk) begin
		if (rst) begin
			pinMeta <= '0;
			pinSync <= '0;
		end else begin
			pinMeta <= {fieldSelect, contactorFeedback, protFieldViolated, warnFieldViolated};
			pinSync <= pinMeta;
		end
	end
	assign selSync = pinSync[TRIPLE_W+2:3];
	assign fbClosed = pinSync[2]; // supply level present = contacts closed
	assign protViol = pinSync[1];
	assign warnViol = pinSync[0];

	// ************************************************************
	// millisecond tick
	// ************************************************************
	logic [$clog2(MS_CYCLES+1)-1:0] divCnt;
	logic msTick;

	always_ff @(posedge clk) begin
		if (rst) begin
			divCnt <= '0;
			msTick <= 1'b0;
		end else begin
			msTick <= (divCnt == '0);
			divCnt <= (divCnt == '0) ? ($bits(divCnt))'(MS_CYCLES - 1) : divCnt - 1'b1;
		end
	end

	// ************************************************************
	// register file
	// ************************************************************
	fscm_cfg_t cfg;
	logic [TRIPLE_W-1:0] cfgDefault, tblIdx, activeTriple, pendTriple;
	logic [31:0] deactMask, standbyMask, timing;
	logic [15:0] sigMap;
	logic [31:0] permitTbl [NUM_TRIPLES];
	logic [IRQ_W-1:0] irqStat, irqEn, irqEvent;
	logic awHeld, wHeld, doWrite, faultClr;
	logic [7:0] awAddr;
	logic [31:0] wData;
	fscm_state_t state;
	logic chgBusy, swFault;

	// address and data may arrive in either order
	always_ff @(posedge clk) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wData <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr > ADDR_IRQ_EN || awAddr[1:0] != 2'h0 ||
					awAddr == ADDR_STATUS || awAddr == ADDR_IRQ_STAT) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;

	// readies registered; from the first clock edge after reset they are the inverse of the holding flags
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= doWrite || !(awHeld || (s_axi_awvalid && s_axi_awready));
			s_axi_wready <= doWrite || !(wHeld || (s_axi_wvalid && s_axi_wready));
		end
	end

	// configuration writes; strobes ignored, whole words only
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg <= '0;
			cfgDefault <= '0;
			deactMask <= '0;
			standbyMask <= '0;
			tblIdx <= '0;
			timing <= '0;
			sigMap <= RST_SIGMAP;
			irqEn <= '0;
			faultClr <= 1'b0;
		end else begin
			faultClr <= doWrite && awAddr == ADDR_CTRL && wData[CTRL_FCLR];
			if (doWrite) begin
				case (awAddr)
					ADDR_CTRL: cfg <= {wData[CTRL_FIXED], wData[CTRL_SWMON], wData[CTRL_FBMON]};
					ADDR_DEFAULT: cfgDefault <= wData[TRIPLE_W-1:0];
					ADDR_DEACT: deactMask <= wData;
					ADDR_TBL_IDX: tblIdx <= wData[TRIPLE_W-1:0];
					ADDR_STANDBY: standbyMask <= wData;
					ADDR_TIMING: timing <= wData;
					ADDR_SIGMAP: sigMap <= wData[15:0];
					ADDR_IRQ_EN: irqEn <= wData[IRQ_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// permitted-transition table, one row of destinations per source
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_TRIPLES; i++) permitTbl[i] <= RST_TBL_ROW;
		end else if (doWrite && awAddr == ADDR_TBL_DATA) begin
			permitTbl[tblIdx] <= wData;
		end
	end

	// read channel, answered one cycle after the address is taken
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CTRL: s_axi_rdata <= {29'h0, cfg.feedbackMonEn, cfg.switchMonEn,
					cfg.fixedMode};
				ADDR_DEFAULT: s_axi_rdata <= {27'h0, cfgDefault};
				ADDR_DEACT: s_axi_rdata <= deactMask;
				ADDR_TBL_IDX: s_axi_rdata <= {27'h0, tblIdx};
				ADDR_TBL_DATA: s_axi_rdata <= permitTbl[tblIdx];
				ADDR_STANDBY: s_axi_rdata <= standbyMask;
				ADDR_TIMING: s_axi_rdata <= timing;
				ADDR_SIGMAP: s_axi_rdata <= {16'h0, sigMap};
				ADDR_STATUS: s_axi_rdata <= {19'h0, activeTriple, 4'h0, 1'b0,
					(state == ST_FAULT), chgBusy, safetySwitchingOutput[0]};
				ADDR_IRQ_STAT: s_axi_rdata <= {28'h0, irqStat};
				ADDR_IRQ_CLR: s_axi_rdata <= '0;
				ADDR_IRQ_EN: s_axi_rdata <= {28'h0, irqEn};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// read ready registered, low from the address edge until the data is taken
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !(s_axi_arvalid && s_axi_arready) && (s_axi_rready || !s_axi_rvalid);
		end
	end

	// ************************************************************
	// triple selection and switchover check
	// ************************************************************
	logic [TRIPLE_W-1:0] reqTriple;
	logic chgReq, permitted, destDeact, standbyNow, demand, violOff;
	logic [15:0] chgCnt;
	logic [17:0] violCnt, violLimit;

	assign reqTriple = cfg.fixedMode ? cfgDefault : selSync;
	assign chgReq = !cfg.fixedMode && !chgBusy && state != ST_FAULT && reqTriple != activeTriple;
	assign permitted = permitTbl[activeTriple][reqTriple];
	assign destDeact = deactMask[reqTriple];
	assign standbyNow = standbyMask[activeTriple];

	// old triple stays monitored until the changeover time has run
	always_ff @(posedge clk) begin
		if (rst) begin
			activeTriple <= '0;
			pendTriple <= '0;
			chgBusy <= 1'b0;
			chgCnt <= '0;
			swFault <= 1'b0;
		end else begin
			swFault <= 1'b0;
			if (cfg.fixedMode) begin
				activeTriple <= cfgDefault;
				chgBusy <= 1'b0;
			end else if (chgReq) begin
				if (cfg.switchMonEn && (!permitted || destDeact)) begin
					swFault <= 1'b1;
				end else begin
					pendTriple <= reqTriple;
					chgBusy <= 1'b1;
					chgCnt <= '0;
				end
			end else if (chgBusy && chgCnt >= timing[TIM_CHG_LSB +: 16]) begin
				activeTriple <= pendTriple;
				chgBusy <= 1'b0;
			end else if (chgBusy && msTick) begin
				chgCnt <= chgCnt + 1'b1;
			end
		end
	end

	// violation delay lengthens while a changeover runs
	assign violLimit = chgBusy ? 18'(SYNC_MS) + 18'(timing[TIM_CHG_LSB +: 16]) +
		18'(timing[TIM_RESP_LSB +: 16]) : 18'(timing[TIM_RESP_LSB +: 16]);
	always_ff @(posedge clk) begin
		if (rst) begin
			violCnt <= '0;
		end else if (!protViol || standbyNow) begin
			violCnt <= '0;
		end else if (msTick && violCnt < violLimit) begin
			violCnt <= violCnt + 1'b1;
		end
	end
	assign violOff = protViol && !standbyNow && violCnt >= violLimit;
	assign demand = !violOff && !standbyNow && !swFault;

	// ************************************************************
	// output and contactor feedback state machine
	// ************************************************************
	logic [9:0] winCnt;
	logic fbFault;

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_OFF;
			safetySwitchingOutput <= 2'b00;
			winCnt <= '0;
			fbFault <= 1'b0;
		end else begin
			fbFault <= 1'b0;
			if (msTick) winCnt <= winCnt + 1'b1;
			case (state)
				ST_OFF: begin
					if (swFault) begin
						state <= ST_FAULT;
					end else if (cfg.feedbackMonEn && !fbClosed) begin
						state <= ST_FAULT;
						fbFault <= 1'b1;
					end else if (demand) begin
						state <= ST_ON_CHECK;
						safetySwitchingOutput <= 2'b11;
						winCnt <= '0;
					end
				end
				ST_ON_CHECK, ST_ON: begin
					if (swFault) begin
						state <= ST_FAULT;
						safetySwitchingOutput <= 2'b00;
					end else if (!demand) begin
						state <= ST_OFF_CHECK;
						safetySwitchingOutput <= 2'b00;
						winCnt <= '0;
					end else if (!cfg.feedbackMonEn) begin
						state <= ST_ON;
					end else if (state == ST_ON_CHECK && !fbClosed) begin
						state <= ST_ON;
					end else if (state == ST_ON && fbClosed) begin
						state <= ST_FAULT;
						safetySwitchingOutput <= 2'b00;
						fbFault <= 1'b1;
					end else if (state == ST_ON_CHECK && winCnt >= 10'(FB_WINDOW_MS)) begin
						state <= ST_FAULT;
						safetySwitchingOutput <= 2'b00;
						fbFault <= 1'b1;
					end
				end
				ST_OFF_CHECK: begin
					if (swFault) begin
						state <= ST_FAULT;
					end else if (!cfg.feedbackMonEn || fbClosed) begin
						state <= ST_OFF;
					end else if (winCnt >= 10'(FB_WINDOW_MS)) begin
						state <= ST_FAULT;
						fbFault <= 1'b1;
					end
				end
				ST_FAULT: begin
					safetySwitchingOutput <= 2'b00;
					if (faultClr) state <= ST_OFF;
				end
				default: begin
					state <= ST_FAULT;
					safetySwitchingOutput <= 2'b00;
				end
			endcase
		end
	end

	// ************************************************************
	// interrupts and indication routing
	// ************************************************************
	logic [NUM_GROUPS-1:0] groups;
	logic [IRQ_W-1:0] irqClr;
	fscm_state_t prevState;
	logic [TRIPLE_W-1:0] prevTriple;

	assign irqClr = (doWrite && awAddr == ADDR_IRQ_CLR) ? wData[IRQ_W-1:0] : '0;
	assign irqEvent = {activeTriple != prevTriple, fbFault, swFault,
		state == ST_FAULT && prevState != ST_FAULT};

	// a new event in the clearing cycle stays set
	always_ff @(posedge clk) begin
		if (rst) begin
			irqStat <= '0;
			irq <= 1'b0;
			prevState <= ST_OFF;
			prevTriple <= '0;
		end else begin
			prevState <= state;
			prevTriple <= activeTriple;
			irqStat <= (irqStat & ~irqClr) | irqEvent;
			irq <= |(((irqStat & ~irqClr) | irqEvent) & irqEn);
		end
	end

	// groups: protective, warning, device on, error, feedback check, diagnosis
	assign groups = {fbClosed, state == ST_ON_CHECK || state == ST_OFF_CHECK,
		state == ST_FAULT, safetySwitchingOutput[0], warnViol, protViol};
	always_ff @(posedge clk) begin
		if (rst) begin
			indication <= '0;
		end else begin
			for (int k = 0; k < NUM_IND; k++) begin
				indication[k] <= (sigMap[k*SIGMAP_STRIDE +: 3] < 3'(NUM_GROUPS)) ?
					groups[sigMap[k*SIGMAP_STRIDE +: 3]] : 1'b0;
			end
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	a_fixed_select: assert property (@(posedge clk) disable iff (rst)
		cfg.fixedMode |=> activeTriple == $past(cfgDefault)) else $error("fixed triple lost");
	a_table_write: assert property (@(posedge clk) disable iff (rst)
		doWrite && awAddr == ADDR_TBL_DATA |=> permitTbl[$past(tblIdx)] == $past(wData))
		else $error("table row not stored");
	a_forbidden_change: assert property (@(posedge clk) disable iff (rst)
		chgReq && cfg.switchMonEn && !permitted |=> ##1 state == ST_FAULT && !safetySwitchingOutput[0])
		else $error("forbidden change not caught");
	a_deact_dest: assert property (@(posedge clk) disable iff (rst)
		chgReq && cfg.switchMonEn && destDeact |=> ##1 safetySwitchingOutput == 2'b00)
		else $error("deactivated destination accepted");
	a_standby_off: assert property (@(posedge clk) disable iff (rst)
		standbyNow && $past(standbyNow) |=> safetySwitchingOutput == 2'b00)
		else $error("outputs on in standby");
	a_closed_before_on: assert property (@(posedge clk) disable iff (rst)
		$rose(safetySwitchingOutput[0]) && cfg.feedbackMonEn |-> $past(fbClosed))
		else $error("switch-on with open feedback");
	a_on_window: assert property (@(posedge clk) disable iff (rst)
		state == ST_ON_CHECK && winCnt >= 10'(FB_WINDOW_MS) && demand && !swFault
		&& cfg.feedbackMonEn && fbClosed |=> state == ST_FAULT) else $error("open window missed");
	a_off_window: assert property (@(posedge clk) disable iff (rst)
		state == ST_OFF_CHECK && winCnt >= 10'(FB_WINDOW_MS) && cfg.feedbackMonEn && !fbClosed
		|=> state == ST_FAULT) else $error("close window missed");
	a_fb_fault_off: assert property (@(posedge clk) disable iff (rst)
		fbFault |-> safetySwitchingOutput == 2'b00) else $error("outputs on after feedback fault");
	a_stuck_closed: assert property (@(posedge clk) disable iff (rst)
		state == ST_ON && demand && cfg.feedbackMonEn && fbClosed |=> state == ST_FAULT)
		else $error("closed feedback while on");
	a_fault_lock: assert property (@(posedge clk) disable iff (rst)
		state == ST_FAULT && !faultClr |=> state == ST_FAULT && safetySwitchingOutput == 2'b00)
		else $error("fault lock left");
	a_checked_change: assert property (@(posedge clk) disable iff (rst)
		!cfg.fixedMode && $past(!cfg.fixedMode) && activeTriple != $past(activeTriple)
		|-> $past(chgBusy)) else $error("triple changed unchecked");

endmodule : fscm_top

// >>> testbench/fscm_contactor_model.sv
`timescale 1ns/1ps
// ************************************************************
// downstream contactor with a normally closed feedback contact
// ************************************************************
module fscm_contactor_model #(
	parameter int SWITCH_CYCLES = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// coil drive and commanded fault
	input wire logic coilOn,
	input wire logic stuck,
	input wire logic stuckOpen,
	// feedback contact, high = closed
	output logic feedback
);
	int cnt;

	// contact follows the coil after a mechanical delay; stuck never opens, stuckOpen never closes
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= 0;
			feedback <= 1'b1;
		end else if (coilOn == feedback && !(coilOn && stuck) && !(!coilOn && stuckOpen)) begin
			cnt <= cnt + 1;
			if (cnt >= SWITCH_CYCLES) begin
				feedback <= !coilOn; // opens after on, closes after off
				cnt <= 0;
			end
		end else begin
			cnt <= 0;
		end
	end
endmodule : fscm_contactor_model

// >>> testbench/fscm_top_tb.sv
`timescale 1ns/1ps
module fscm_top_tb import fscm_pkg::*;;
	// ************************************************************
	// stimulus and observed signals
	// ************************************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
	logic [31:0] wData = 32'h00000000;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic awReady, wReady, bValid, arReady, rValid, irq, fb;
	logic [1:0] bResp, rResp, ssOut;
	logic [31:0] rData;
	logic [4:0] fieldSel = 5'h00;
	logic protViol = 1'b0, warnViol = 1'b0, stuck = 1'b0, stuckOpen = 1'b0;
	logic [3:0] ind;
	int numErrors = 0;
	int nChecks = 0;

	// short ms so the 500 ms window is about 5000 cycles
	fscm_top #(.MS_CYCLES(10)) dut (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .fieldSelect(fieldSel), .contactorFeedback(fb),
		.protFieldViolated(protViol), .warnFieldViolated(warnViol),
		.safetySwitchingOutput(ssOut), .indication(ind), .irq(irq));
	fscm_contactor_model model (.clk(clk), .rst(rst), .coilOn(ssOut[0]), .stuck(stuck),
		.stuckOpen(stuckOpen), .feedback(fb));

	// free running 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end

	// ************************************************************
	// checking and bus tasks
	// ************************************************************
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic timeout;
		chk_val(32'h00000000, 32'h00000001);
		finish_test();
	endtask : timeout

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge clk);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (awReady) awValid <= 1'b0;
			if (wReady) wValid <= 1'b0;
			if (bValid) break;
		end
		bReady <= 1'b0;
		r = bResp;
		if (i == 100) timeout();
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (arReady) arValid <= 1'b0;
			if (rValid) break;
		end
		rReady <= 1'b0;
		d = rData;
		r = rResp;
		if (i == 100) timeout();
	endtask : axi_rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk_val({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk_val(d & m, e);
		chk_val({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : rc

	// bounded wait for the safety outputs to reach a level
	task automatic wo(input logic [1:0] e, input int lim);
		int i;
		for (i = 0; i < lim && ssOut !== e; i++) @(posedge clk);
		if (i == lim) timeout();
		chk_val({30'h0, ssOut}, {30'h0, e});
	endtask : wo

	task automatic do_reset;
		rst <= 1'b1;
		fieldSel <= 5'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : do_reset

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic test_regs;
		logic [31:0] d;
		logic [1:0] r;
		rc(ADDR_SIGMAP, 32'h0000FFFF, {16'h0, RST_SIGMAP});
		rc(ADDR_TBL_DATA, 32'hFFFFFFFF, RST_TBL_ROW);
		wr(ADDR_TBL_DATA, 32'h00000005);
		rc(ADDR_TBL_DATA, 32'hFFFFFFFF, 32'h00000005);
		axi_rd(8'h30, d, r);
		chk_val(d, 32'h00000000);
		chk_val({30'h0, r}, {30'h0, RESP_SLVERR});
		axi_wr(ADDR_STATUS, 32'hFFFFFFFF, r);
		chk_val({30'h0, r}, {30'h0, RESP_SLVERR});
		$display("test_regs finished");
	endtask : test_regs

	task automatic test_fixed;
		do_reset();
		wr(ADDR_DEFAULT, 32'h00000003);
		wr(ADDR_CTRL, 32'h00000001 << CTRL_FIXED);
		fieldSel <= 5'h07;
		repeat (10) @(posedge clk);
		rc(ADDR_STATUS, 32'h00001F00, 32'h00000300);
		wr(ADDR_IRQ_EN, 32'h00000001 << IRQ_CHANGED);
		repeat (3) @(posedge clk);
		chk_val({31'h0, irq}, 32'h00000001);
		wr(ADDR_IRQ_CLR, 32'h00000001 << IRQ_CHANGED);
		repeat (3) @(posedge clk);
		chk_val({31'h0, irq}, 32'h00000000);
		$display("test_fixed finished");
	endtask : test_fixed

	task automatic test_switch;
		do_reset();
		wr(ADDR_CTRL, 32'h00000001 << CTRL_SWMON);
		wr(ADDR_TBL_DATA, 32'h00000002); // only 0 -> 1 from triple 0
		wr(ADDR_IRQ_EN, 32'h00000001 << IRQ_SWFAULT);
		wo(2'b11, 100);
		fieldSel <= 5'h01; // request well ahead of need
		repeat (10) @(posedge clk);
		rc(ADDR_STATUS, 32'h00001F00, 32'h00000100);
		fieldSel <= 5'h00; // leave the covering triple
		repeat (10) @(posedge clk);
		wr(ADDR_DEACT, 32'h00000002);
		fieldSel <= 5'h01;
		wo(2'b00, 50);
		fieldSel <= 5'h00;
		repeat (100) @(posedge clk);
		chk_val({30'h0, ssOut}, 32'h00000000);
		wr(ADDR_CTRL, 32'h0000000A);
		wo(2'b11, 100);
		wr(ADDR_IRQ_CLR, 32'h00000001 << IRQ_SWFAULT);
		chk_val({31'h0, irq}, 32'h00000000);
		fieldSel <= 5'h02;
		wo(2'b00, 50);
		chk_val({31'h0, irq}, 32'h00000001);
		rc(ADDR_STATUS, 32'h00001F04, 32'h00000004);
		$display("test_switch finished");
	endtask : test_switch

	task automatic test_standby;
		do_reset();
		wr(ADDR_STANDBY, 32'h00000010);
		wo(2'b11, 100);
		fieldSel <= 5'h04;
		wo(2'b00, 100);
		fieldSel <= 5'h00;
		wo(2'b11, 100);
		$display("test_standby finished");
	endtask : test_standby

	task automatic test_feedback;
		do_reset();
		wr(ADDR_TIMING, 32'h00010000);
		// outputs came on at reset release; let the contact open before monitoring starts
		repeat (30) @(posedge clk);
		wr(ADDR_CTRL, 32'h00000001 << CTRL_FBMON);
		wr(ADDR_IRQ_EN, 32'h00000001 << IRQ_FBFAULT);
		wo(2'b11, 200);
		protViol <= 1'b1;
		warnViol <= 1'b1;
		repeat (5) @(posedge clk);
		chk_val({28'h0, ind & 4'h3}, 32'h00000003);
		wo(2'b00, 40);
		protViol <= 1'b0;
		warnViol <= 1'b0;
		wo(2'b11, 400);
		repeat (200) @(posedge clk);
		rc(ADDR_STATUS, 32'h00000004, 32'h00000000);
		stuck <= 1'b1; // contact welded shut
		protViol <= 1'b1;
		wo(2'b00, 40);
		protViol <= 1'b0;
		wo(2'b11, 400);
		wo(2'b00, 5200);
		rc(ADDR_STATUS, 32'h00000004, 32'h00000004);
		chk_val({31'h0, irq}, 32'h00000001);
		stuck <= 1'b0;
		wr(ADDR_CTRL, 32'h0000000C);
		wo(2'b11, 400);
		repeat (40) @(posedge clk);
		stuckOpen <= 1'b1; // contact never closes again after switch-off
		protViol <= 1'b1;
		wo(2'b00, 40);
		protViol <= 1'b0;
		repeat (5100) @(posedge clk);
		rc(ADDR_STATUS, 32'h00000004, 32'h00000004);
		stuckOpen <= 1'b0;
		$display("test_feedback finished");
	endtask : test_feedback

	// one sequence, one verdict
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		test_regs();
		test_fixed();
		test_switch();
		test_standby();
		test_feedback();
		finish_test();
	end
endmodule : fscm_top_tb
